// [core/qbio_regs.svh]
// Register offsets, reset values and timing counts for the quasi-bidirectional port block
// Contract
// R1 - Five bit-addressable 8-bit ports; ports one to four are quasi-bidirectional.
// R2 - Very weak pull-up is on while the latch bit holds one.
// R3 - Weak pull-up is on only while the sensed pin level is one.
// R4 - A latch rising from zero to one turns on strong pull-up for two clocks.
// R5 - A latch bit at zero drives the pin low strongly.
// R6 - Port zero is open-drain by default; latch one leaves pin undriven.
// R7 - Option bit zero enables port zero pull-ups on all eight pins.
// R8 - During external memory access ports zero and two drive strongly both ways; port zero releases its pins in a data phase without i_ext_data_oe.
// R9 - Port zero carries low address and data; port two carries high address.
// R10 - External program execution blocks access to port zero and two latches.
// R11 - Read-modify-write reads the latch; ordinary reads return the pin state.
// R12 - Bit instructions read the whole latch, change one bit, write the byte.
// R13 - Ports zero to three reset their latches to all ones.
// R14 - Port zero option register resets to zero; bits seven to one reserved.
// R15 - Port four is a quasi-bidirectional latch at its own address, reset ones.
// R16 - Strong pulse counter starts at the rising latch write and restarts on new ones.
// R17 - Pin levels pass a synchroniser before reaching the read data path.
`ifndef QBIO_REGS_SVH
`define QBIO_REGS_SVH
`define QBIO_ADDR_PORT0     8'h80
`define QBIO_ADDR_P0OPT     8'h86
`define QBIO_ADDR_PORT1     8'h90
`define QBIO_ADDR_PORT2     8'ha0
`define QBIO_ADDR_PORT3     8'hb0
`define QBIO_ADDR_PORT4     8'hd8
`define QBIO_LATCH_RST      8'hff
`define QBIO_P0OPT_RST      8'h00
`define QBIO_P0OPT_PUEN_BIT 0
`define QBIO_CLK_PERIOD_NS  5
`define QBIO_STRONG_CLKS    2
`endif

// [core/qbio_pkg.sv]
// Types shared by the quasi-bidirectional port block
package qbio_pkg;
   typedef logic [7:0] qbio_byte_t;
   typedef logic [2:0] qbio_port_t;
endpackage : qbio_pkg

// [core/qbio_pin.sv]
// One quasi-bidirectional pin: pull-up controls, strong pulse and input synchroniser
`timescale 1ns/1ps
`include "qbio_regs.svh"
module qbio_pin
   import qbio_pkg::*;
#(
   parameter int STRONG_CLKS = `QBIO_STRONG_CLKS
) (
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   input  wire logic i_latch,
   input  wire logic i_latch_rise,
   input  wire logic i_pullup_en,
   input  wire logic i_bus_mode,
   input  wire logic i_bus_out,
   input  wire logic i_pin,
   output logic      o_pin_sync,
   output logic      o_very_weak,
   output logic      o_weak,
   output logic      o_strong,
   output logic      o_pull_down
);
   // =====================================================
   // Input synchroniser
   logic [2:0] sync_reg;
   logic       sense_reg;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync_reg  <= 3'h7;
         sense_reg <= 1'b1;
      end else begin
         sync_reg <= {sync_reg[1:0], i_pin};
         if (sync_reg[1] == sync_reg[2]) begin // see R17
            sense_reg <= sync_reg[2];
         end
      end
   end
   assign o_pin_sync = sense_reg;

   // =====================================================
   // Strong pull-up pulse counter
   logic [3:0] cnt_reg;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_reg <= 4'h0;
      end else if (i_latch_rise) begin
         cnt_reg <= 4'(STRONG_CLKS); // see R4 see R16
      end else if (cnt_reg != 4'h0) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end

   // =====================================================
   // Drive controls
   always_comb begin
      if (i_bus_mode) begin
         o_very_weak = 1'b0;
         o_weak      = 1'b0;
         o_strong    = i_bus_out;  // see R8
         o_pull_down = ~i_bus_out; // see R8
      end else begin
         o_very_weak = i_pullup_en & i_latch;              // see R2 see R6
         o_weak      = i_pullup_en & i_latch & sense_reg;  // see R3
         // Pulse is cut when the latch drops so it never fights the pull-down
         o_strong    = i_pullup_en & i_latch & (cnt_reg != 4'h0); // see R4 see R5
         o_pull_down = ~i_latch;                           // see R5
      end
   end
endmodule : qbio_pin

// [core/qbio_ports.sv]
// Five 8-bit port latches with register access and per-pin drive control
`timescale 1ns/1ps
`include "qbio_regs.svh"
module qbio_ports
   import qbio_pkg::*;
#(
   parameter int NUM_PORTS = 5,
   parameter int STRONG_NS = 2 * `QBIO_CLK_PERIOD_NS
) (
   input  wire logic                     i_clk,
   input  wire logic                     i_arst_n,
   input  wire logic [7:0]               i_sfr_addr,
   input  wire logic                     i_sfr_wr,
   input  wire logic [7:0]               i_sfr_wdata,
   input  wire logic                     i_sfr_rd,
   input  wire logic                     i_sfr_rmw,
   input  wire logic                     i_sfr_bit_op,
   input  wire logic [2:0]               i_sfr_bit_sel,
   input  wire logic                     i_sfr_bit_val,
   output logic      [7:0]               o_sfr_rdata,
   output logic                          o_sfr_hit,
   input  wire logic                     i_ext_fetch,
   input  wire logic                     i_ext_access,
   input  wire logic [7:0]               i_ext_addr_lo,
   input  wire logic [7:0]               i_ext_addr_hi,
   input  wire logic                     i_ext_data_phase,
   input  wire logic [7:0]               i_ext_wdata,
   input  wire logic                     i_ext_data_oe,
   output logic      [7:0]               o_ext_rdata,
   input  wire logic [8*NUM_PORTS-1:0]   i_pin,
   output logic      [8*NUM_PORTS-1:0]   o_very_weak,
   output logic      [8*NUM_PORTS-1:0]   o_weak,
   output logic      [8*NUM_PORTS-1:0]   o_strong,
   output logic      [8*NUM_PORTS-1:0]   o_pull_down
);
   localparam int STRONG_CLKS = (STRONG_NS + `QBIO_CLK_PERIOD_NS - 1) / `QBIO_CLK_PERIOD_NS;

   // =====================================================
   // Address decode
   logic [NUM_PORTS-1:0] sel;
   logic                 sel_opt;
   logic [7:0]           port_addr [0:4];
   assign port_addr[0] = `QBIO_ADDR_PORT0;
   assign port_addr[1] = `QBIO_ADDR_PORT1;
   assign port_addr[2] = `QBIO_ADDR_PORT2;
   assign port_addr[3] = `QBIO_ADDR_PORT3;
   assign port_addr[4] = `QBIO_ADDR_PORT4; // see R15
   assign sel_opt = (i_sfr_addr == `QBIO_ADDR_P0OPT);

   // Ports zero and two are locked while executing externally
   logic [NUM_PORTS-1:0] locked;
   logic [NUM_PORTS-1:0] bus_port;

   logic [7:0] latch_reg [0:NUM_PORTS-1];
   logic [7:0] sync_byte [0:NUM_PORTS-1];
   logic       pullup_en_reg;

   // =====================================================
   // Option register
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pullup_en_reg <= 1'b0; // see R14
      end else if (i_sfr_wr && sel_opt) begin
         pullup_en_reg <= i_sfr_wdata[`QBIO_P0OPT_PUEN_BIT]; // see R7
      end
   end

   // =====================================================
   // Port latches and pins
   genvar p, b;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port // see R1
         logic [7:0] wr_val;
         logic [7:0] latch_next;
         logic [7:0] bus_out;
         assign sel[p]      = (i_sfr_addr == port_addr[p]);
         assign locked[p]   = i_ext_fetch && (p == 0 || p == 2); // see R10
         assign bus_port[p] = i_ext_access && (p == 0 || p == 2); // see R8
         assign bus_out     = (p == 0) ? (i_ext_data_phase ? i_ext_wdata : i_ext_addr_lo) : i_ext_addr_hi; // see R9
         always_comb begin
            wr_val = latch_reg[p];
            if (i_sfr_bit_op) begin
               wr_val[i_sfr_bit_sel] = i_sfr_bit_val; // see R12
            end else begin
               wr_val = i_sfr_wdata;
            end
            latch_next = (i_sfr_wr && sel[p] && !locked[p]) ? wr_val : latch_reg[p];
         end
         always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               latch_reg[p] <= `QBIO_LATCH_RST; // see R13
            end else begin
               latch_reg[p] <= latch_next;
            end
         end
         for (b = 0; b < 8; b++) begin : g_bit
            logic rise;
            logic bus_mode;
            assign rise     = ~latch_reg[p][b] & latch_next[b];
            assign bus_mode = bus_port[p] && (p != 0 || i_ext_data_oe || !i_ext_data_phase);
            qbio_pin #(
               .STRONG_CLKS (STRONG_CLKS)
            ) u_pin (
               .i_clk        (i_clk),
               .i_arst_n     (i_arst_n),
               .i_latch      (latch_reg[p][b] | bus_port[p]),
               .i_latch_rise (rise),
               .i_pullup_en  ((p != 0) | pullup_en_reg), // see R6 see R7
               .i_bus_mode   (bus_mode),
               .i_bus_out    (bus_out[b]),
               .i_pin        (i_pin[8*p+b]),
               .o_pin_sync   (sync_byte[p][b]),
               .o_very_weak  (o_very_weak[8*p+b]),
               .o_weak       (o_weak[8*p+b]),
               .o_strong     (o_strong[8*p+b]),
               .o_pull_down  (o_pull_down[8*p+b])
            );
         end
      end
   endgenerate

   assign o_ext_rdata = sync_byte[0];

   // =====================================================
   // Read data
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sfr_rdata <= 8'h00;
      end else if (i_sfr_rd) begin
         o_sfr_rdata <= 8'h00;
         if (sel_opt) begin
            o_sfr_rdata <= {7'h00, pullup_en_reg};
         end
         for (int i = 0; i < NUM_PORTS; i++) begin
            if (sel[i] && !locked[i]) begin
               o_sfr_rdata <= (i_sfr_rmw || i_sfr_bit_op) ? latch_reg[i] : sync_byte[i]; // see R11
            end
         end
      end
   end

   always_comb begin
      o_sfr_hit = sel_opt;
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (sel[i] && !locked[i]) begin
            o_sfr_hit = 1'b1;
         end
      end
   end
endmodule : qbio_ports

// [bench/qbio_ports_sva.sv]
// Concurrent checks on the pin controls and register access of the port block
`timescale 1ns/1ps
`include "qbio_regs.svh"
module qbio_ports_sva #(parameter int NUM_PORTS = 5) (
   input wire logic                   i_clk, i_arst_n, i_sfr_wr, i_sfr_rd, i_ext_fetch,
   input wire logic                   i_ext_access, i_ext_data_phase, i_ext_data_oe, o_sfr_hit,
   input wire logic [7:0]             i_sfr_addr, i_ext_addr_lo, i_ext_addr_hi, o_sfr_rdata,
   input wire logic [8*NUM_PORTS-1:0] o_very_weak, o_weak, o_strong, o_pull_down);
   localparam int W = 8*NUM_PORTS;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   wire logic lk = i_ext_fetch && (i_sfr_addr == `QBIO_ADDR_PORT0 || i_sfr_addr == `QBIO_ADDR_PORT2);
   vweak_latch_a:
      assert property (!i_ext_access |-> o_very_weak[W-1:8] == ~o_pull_down[W-1:8]) else $error("very weak pull-up");
   weak_low_a:
      assert property ((o_weak & o_pull_down) == '0) else $error("weak pull-up on a low pin");
   drive_clash_a:
      assert property ((o_strong & o_pull_down) == '0) else $error("strong pull-up against pull-down");
   strong_two_a:
      assert property ($rose(o_strong[8]) |=> o_strong[8] ##1 !o_strong[8]) else $error("strong pulse length");
   strong_cause_a:
      assert property ($rose(o_strong[8]) |-> $past(i_sfr_wr) && $past(i_sfr_addr) == `QBIO_ADDR_PORT1)
      else $error("strong pulse without write");
   lock_hit_a:
      assert property (lk |-> !o_sfr_hit) else $error("locked port reported as mapped");
   lock_read_a:
      assert property (lk && i_sfr_rd |=> o_sfr_rdata == 8'h00) else $error("locked port read data");
   bus_hi_a:
      assert property (i_ext_access |-> o_strong[23:16] == i_ext_addr_hi && o_pull_down[23:16] == ~i_ext_addr_hi)
      else $error("high address drive");
   bus_lo_a:
      assert property (i_ext_access && !i_ext_data_phase |-> o_strong[7:0] == i_ext_addr_lo
         && o_pull_down[7:0] == ~i_ext_addr_lo) else $error("low address drive");
   bus_release_a:
      assert property (i_ext_access && i_ext_data_phase && !i_ext_data_oe |-> (o_strong[7:0] | o_pull_down[7:0]) == 8'h00)
      else $error("data lines not released");
   cover property ($rose(o_strong[8]));
   cover property (lk && i_sfr_rd);
   cover property (i_ext_access && i_ext_data_phase);
endmodule : qbio_ports_sva
bind qbio_ports qbio_ports_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (.*);

// [bench/qbio_pins_model.sv]
// Pins and the external devices hanging on them
`timescale 1ns/1ps
module qbio_pins_model #(parameter int N = 40) (
   input wire logic         i_clk, i_ext_drv_en,
   input wire logic [7:0]   i_ext_drv,
   input wire logic [N-1:0] i_ext_low, i_very_weak, i_weak, i_strong, i_pull_down,
   output logic     [N-1:0] o_pin);
   logic tgl = 1'b0;
   always_ff @(posedge i_clk) tgl <= ~tgl;
   always_comb begin
      for (int b = 0; b < N; b++) begin
         if (i_pull_down[b] || i_ext_low[b]) o_pin[b] = 1'b0;
         else if (i_ext_drv_en && b < 8) o_pin[b] = i_ext_drv[b%8];
         else if (i_strong[b] || i_weak[b] || i_very_weak[b]) o_pin[b] = 1'b1;
         else o_pin[b] = tgl ^ b[0];
      end
   end
endmodule : qbio_pins_model

// [bench/test_qbio_ports.sv]
// Self-checking bench for the quasi-bidirectional port block
`timescale 1ns/1ps
`include "qbio_regs.svh"
module test_qbio_ports import qbio_pkg::*;;
   logic i_clk = 0, i_arst_n = 0, i_sfr_wr = 0, i_sfr_rd = 0, i_sfr_rmw = 0, i_sfr_bit_op = 0, i_sfr_bit_val = 0;
   logic i_ext_fetch = 0, i_ext_access = 0, i_ext_data_phase = 0, i_ext_data_oe = 0, drv_en = 0, rd_q = 0, o_sfr_hit;
   logic [2:0] i_sfr_bit_sel = 0;
   logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, i_ext_addr_lo = 0, i_ext_addr_hi = 0, i_ext_wdata = 0, drv = 0, v;
   logic [7:0] o_sfr_rdata, o_ext_rdata;
   logic [39:0] i_pin, ext_low = '0, o_very_weak, o_weak, o_strong, o_pull_down;
   logic [7:0] ad [6] = '{`QBIO_ADDR_PORT0, `QBIO_ADDR_PORT1, `QBIO_ADDR_PORT2, `QBIO_ADDR_PORT3,
                         `QBIO_ADDR_PORT4, `QBIO_ADDR_P0OPT};
   qbio_byte_t exp_q[$];
   int error_cnt = 0, tests_run = 0, n;
   qbio_ports dut (.*);
   qbio_pins_model u_pins (.i_clk(i_clk), .i_ext_drv_en(drv_en), .i_ext_drv(drv), .i_ext_low(ext_low),
      .i_very_weak(o_very_weak), .i_weak(o_weak), .i_strong(o_strong), .i_pull_down(o_pull_down), .o_pin(i_pin));
   initial forever #2.5 i_clk = ~i_clk;
   task automatic chk(input logic [7:0] g, e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wrap_up;
      $display("Checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task automatic cyc(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask : cyc
   // One register cycle; for a read, d is the expected byte
   task automatic sfr(input logic w, r, m, b, input logic [7:0] a, d);
      cyc(1);
      {i_sfr_wr, i_sfr_rd, i_sfr_rmw, i_sfr_bit_op, i_sfr_addr} = {w, r, m, b, a};
      if (b) {i_sfr_bit_sel, i_sfr_bit_val} = d[3:0];
      else i_sfr_wdata = d;
      if (r) exp_q.push_back(d);
      cyc(1);
      {i_sfr_wr, i_sfr_rd, i_sfr_bit_op} = 3'h0;
   endtask : sfr
   always @(posedge i_clk) begin
      if (rd_q) chk(o_sfr_rdata, exp_q.pop_front());
      rd_q <= i_sfr_rd;
   end
   initial begin
      #500000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      n = $urandom(32'h3e7e);
      cyc(4);
      i_arst_n = 1;
      foreach (ad[i]) sfr(0, 1, 1, 0, ad[i], i == 5 ? 8'h00 : 8'hff);
      foreach (ad[i]) begin
         v = 8'($urandom);
         sfr(1, 0, 0, 0, ad[i], v);
         sfr(0, 1, 1, 0, ad[i], i == 5 ? {7'h00, v[0]} : v);
      end
      sfr(1, 0, 0, 0, ad[1], 8'hff);
      ext_low[11] = 1'b1;
      cyc(6);
      sfr(0, 1, 0, 0, ad[1], 8'hf7);
      sfr(0, 1, 1, 0, ad[1], 8'hff);
      chk({7'h00, o_weak[11]}, 8'h00);
      chk(o_very_weak[15:8], 8'hff);
      chk(o_weak[15:8], 8'hf7);
      ext_low = '0;
      sfr(1, 0, 0, 0, ad[1], 8'h00);
      chk(o_pull_down[15:8], 8'hff);
      sfr(1, 0, 0, 0, ad[1], 8'h01);
      n = 0;
      repeat (4) begin
         n += o_strong[8];
         cyc(1);
      end
      chk(n[7:0], 8'h02);
      sfr(1, 0, 0, 0, ad[3], 8'h00);
      ext_low[24] = 1'b1;
      for (int b = 0; b < 8; b += 2) sfr(1, 0, 0, 1, ad[3], {4'h0, b[2:0], 1'b1});
      sfr(1, 0, 0, 1, ad[3], 8'h04);
      sfr(0, 1, 1, 1, ad[3], 8'h51);
      cyc(4);
      sfr(0, 1, 0, 0, ad[3], 8'h50);
      ext_low[24] = 1'b0;
      sfr(1, 0, 0, 0, ad[0], 8'hff);
      sfr(1, 0, 0, 0, ad[5], 8'hff);
      sfr(0, 1, 1, 0, ad[5], 8'h01);
      chk({7'h00, o_sfr_hit}, 8'h01);
      chk(o_very_weak[7:0], 8'hff);
      sfr(1, 0, 0, 0, ad[5], 8'h00);
      chk(o_very_weak[7:0] | o_weak[7:0] | o_strong[7:0] | o_pull_down[7:0], 8'h00);
      sfr(0, 1, 1, 0, 8'h55, 8'h00);
      chk({7'h00, o_sfr_hit}, 8'h00);
      sfr(1, 0, 0, 0, ad[2], 8'h3c);
      i_ext_fetch = 1;
      sfr(1, 0, 0, 0, ad[2], 8'h00);
      sfr(0, 1, 1, 0, ad[2], 8'h00);
      chk({7'h00, o_sfr_hit}, 8'h00);
      i_ext_fetch = 0;
      sfr(0, 1, 1, 0, ad[2], 8'h3c);
      chk({7'h00, o_sfr_hit}, 8'h01);
      // Mid-run reset: latches and option return to their reset values
      cyc(1);
      i_arst_n = 0;
      cyc(2);
      i_arst_n = 1;
      sfr(0, 1, 1, 0, ad[2], 8'hff);
      sfr(0, 1, 1, 0, ad[5], 8'h00);
      {i_ext_access, i_ext_data_oe, i_ext_addr_hi, i_ext_addr_lo, i_ext_wdata} = {2'b11, 24'($urandom)};
      cyc(1);
      chk(o_strong[23:16], i_ext_addr_hi);
      chk(o_pull_down[7:0], ~i_ext_addr_lo);
      i_ext_data_phase = 1;
      cyc(1);
      chk(o_strong[7:0], i_ext_wdata);
      {i_ext_data_oe, drv_en, drv} = {2'b01, 8'($urandom)};
      cyc(6);
      chk(o_ext_rdata, drv);
      {i_ext_access, i_ext_data_phase, drv_en} = 3'h0;
      cyc(2);
      wrap_up();
   end
endmodule : test_qbio_ports
